//--- ecpl_defines.vh
`ifndef ECPL_DEFINES_VH
`define ECPL_DEFINES_VH

// operating mode codes of the three-bit mode field
`define ECPL_MODE_COMPAT 3'h2
`define ECPL_MODE_ECP 3'h3

// buffer shape: 16 entries of tag plus byte
`define ECPL_FIFO_DEPTH 16
`define ECPL_FIFO_WIDTH 9

// clock rate and compatibility strobe timing
`define ECPL_CLK_MHZ 40
`define ECPL_SETUP_NS 500
`define ECPL_STB_NS 500
`define ECPL_HOLD_NS 500

// reverse command byte fields
`define ECPL_CMD_ADDR_BIT 7
`define ECPL_RLE_MSB 6

`endif

//--- ecpl_link.v
// Notes on behaviour
// - one sixteen-byte FIFO serves both directions
// - no negotiation; DMA-driven burst channel both ways
// - compatibility mode strobes bytes out automatically
// - run-length byte consumed, next byte repeated
// - strobe latches byte, interlocked with busy
// - host lowers hostack to request reverse byte
// - hostack level marks forward command or data
// - ninit low requests reverse, high returns forward
// - host drives bus only after direction acknowledge
// - nselectin held high throughout ECP mode
// - fault hint may be ignored by host
// - fault raises error interrupt, ECP forward only
// - behaves as ordinary printer port otherwise
// - data lines carry address, data or count
// - mode 011 ECP FIFO, 010 compatibility FIFO
// - tagged address bytes queued, both directions

`timescale 1ns/1ps
`default_nettype none
`include "ecpl_defines.vh"

module ecpl_fifo #(
  parameter WIDTH = `ECPL_FIFO_WIDTH,
  parameter DEPTH = `ECPL_FIFO_DEPTH,
  parameter AW = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // fill side
  input wire in_valid_i,
  input wire [WIDTH-1:0] in_data_i,
  output wire in_ready_o,
  // drain side
  output wire out_valid_o,
  output wire [WIDTH-1:0] out_data_o,
  input wire out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push, pop;
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end
  // pointers wrap on depth so a depth that is not a power of two still works
  always @(posedge mclk_i) begin
    if (rst_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // ecpl_fifo

module ecpl_link #(
  parameter DEPTH = `ECPL_FIFO_DEPTH
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_i,
  // mode and direction control
  input wire [2:0] mode_i,
  input wire direction_i,
  // host write stream (forward), tag high marks address or count byte
  input wire wr_valid_i,
  input wire [7:0] wr_data_i,
  input wire wr_tag_i,
  output wire wr_ready_o,
  // host read stream (reverse), tag high marks a channel address
  output wire rd_valid_o,
  output wire [7:0] rd_data_o,
  output wire rd_tag_o,
  input wire rd_ready_i,
  // host status
  output wire dma_req_o,
  output wire fault_irq_o,
  output wire dir_rev_o,
  // peripheral data lines
  input wire [7:0] pd_i,
  output wire [7:0] pd_o,
  output wire pd_oe_o,
  // peripheral control outputs
  output wire nstrobe_o,
  output wire nautofd_o,
  output wire ninit_o,
  output wire nselectin_o,
  // peripheral status inputs
  input wire busy_i,
  input wire nack_i,
  input wire perror_i,
  input wire select_i,
  input wire nfault_i
);
  localparam [3:0] S_FIDLE = 4'h0, S_FSETUP = 4'h1, S_FSTB = 4'h2, S_FREL = 4'h3;
  localparam [3:0] S_CSETUP = 4'h4, S_CSTB = 4'h5, S_CHOLD = 4'h6, S_TOREV = 4'h7;
  localparam [3:0] S_RIDLE = 4'h8, S_RWAIT = 4'h9, S_RREL = 4'hA, S_TOFWD = 4'hB;
  // least times round up to whole cycles
  localparam integer SETUP_CYC = (`ECPL_SETUP_NS * `ECPL_CLK_MHZ + 999) / 1000;
  localparam integer STB_CYC = (`ECPL_STB_NS * `ECPL_CLK_MHZ + 999) / 1000;
  localparam integer HOLD_CYC = (`ECPL_HOLD_NS * `ECPL_CLK_MHZ + 999) / 1000;
  // pin synchronisers: stage one feeds stage two only
  reg [12:0] pin_s1_reg, pin_s2_reg;
  wire [7:0] pd_s;
  wire busy_s, nack_s, perror_s, nfault_s;
  reg [3:0] state_reg, state_next;
  reg [7:0] tmr_reg, tmr_next;
  reg [7:0] pd_reg, pd_next;
  reg pd_oe_reg, pd_oe_next;
  reg nstrobe_reg, nstrobe_next;
  reg hostack_reg, hostack_next;
  reg ninit_reg, ninit_next;
  reg dir_rev_reg, dir_rev_next;
  reg fault_irq_reg;
  // reverse side decompression
  reg rle_pend_reg, rle_pend_next;
  reg [6:0] rle_cnt_reg, rle_cnt_next;
  reg [7:0] rep_left_reg, rep_left_next;
  reg [8:0] rep_word_reg, rep_word_next;
  wire mode_ecp, mode_compat;
  wire f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  wire [8:0] f_in_data, f_out_data;
  reg fwd_pop;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_s1_reg <= 13'h1FFF;
      pin_s2_reg <= 13'h1FFF;
    end else begin
      pin_s1_reg <= {nfault_i, select_i, perror_i, nack_i, busy_i, pd_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign pd_s = pin_s2_reg[7:0];
  assign busy_s = pin_s2_reg[8];
  assign nack_s = pin_s2_reg[9];
  assign perror_s = pin_s2_reg[10];
  assign nfault_s = pin_s2_reg[12];
  assign mode_ecp = (mode_i == `ECPL_MODE_ECP);
  assign mode_compat = (mode_i == `ECPL_MODE_COMPAT);
  // one buffer, its ends swapped by the live direction
  assign f_in_valid = dir_rev_reg ? (rep_left_reg != 8'h00) : wr_valid_i;
  assign f_in_data = dir_rev_reg ? rep_word_reg : {wr_tag_i, wr_data_i};
  assign f_out_ready = dir_rev_reg ? rd_ready_i : fwd_pop;

  ecpl_fifo #(
    .WIDTH(`ECPL_FIFO_WIDTH),
    .DEPTH(DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(f_in_valid),
    .in_data_i(f_in_data),
    .in_ready_o(f_in_ready),
    .out_valid_o(f_out_valid),
    .out_data_o(f_out_data),
    .out_ready_i(f_out_ready)
  );

  // host side handshakes; a stalled reverse drain backs up to hostack
  assign wr_ready_o = !dir_rev_reg && f_in_ready;
  assign rd_valid_o = dir_rev_reg && f_out_valid;
  assign rd_data_o = f_out_data[7:0];
  assign rd_tag_o = f_out_data[8];
  assign dma_req_o = (mode_ecp || mode_compat) && (dir_rev_reg ? f_out_valid : f_in_ready);

  assign pd_o = pd_reg;
  assign pd_oe_o = pd_oe_reg;
  assign nstrobe_o = nstrobe_reg;
  assign nautofd_o = hostack_reg;
  assign ninit_o = ninit_reg;
  // ECP holds nselectin high; elsewhere the printer stays selected
  assign nselectin_o = mode_ecp;
  assign fault_irq_o = fault_irq_reg;
  assign dir_rev_o = dir_rev_reg;
  always @* begin
    state_next = state_reg;
    tmr_next = (tmr_reg != 8'h00) ? tmr_reg - 8'h01 : tmr_reg;
    pd_next = pd_reg;
    pd_oe_next = pd_oe_reg;
    nstrobe_next = nstrobe_reg;
    hostack_next = hostack_reg;
    ninit_next = ninit_reg;
    dir_rev_next = dir_rev_reg;
    rle_pend_next = rle_pend_reg;
    rle_cnt_next = rle_cnt_reg;
    rep_left_next = rep_left_reg;
    rep_word_next = rep_word_reg;
    fwd_pop = 1'b0;
    if (f_in_valid && f_in_ready && dir_rev_reg) begin
      rep_left_next = rep_left_reg - 8'h01;
    end
    case (state_reg)
      S_FIDLE: begin
        // the fault hint is never used to turn the bus round
        if (mode_ecp && direction_i && !f_out_valid) begin
          pd_oe_next = 1'b0;
          ninit_next = 1'b0;
          state_next = S_TOREV;
        end else if (mode_ecp && f_out_valid && !busy_s) begin
          pd_next = f_out_data[7:0];
          hostack_next = !f_out_data[8];
          state_next = S_FSETUP;
        end else if (mode_compat && f_out_valid && !busy_s) begin
          pd_next = f_out_data[7:0];
          tmr_next = SETUP_CYC[7:0];
          state_next = S_CSETUP;
        end
      end
      S_FSETUP: begin
        nstrobe_next = 1'b0;
        state_next = S_FSTB;
      end
      S_FSTB: begin
        if (busy_s) begin
          nstrobe_next = 1'b1;
          state_next = S_FREL;
        end
      end
      S_FREL: begin
        if (!busy_s) begin
          fwd_pop = 1'b1;
          hostack_next = 1'b1;
          state_next = S_FIDLE;
        end
      end
      S_CSETUP: begin
        if (tmr_reg <= 8'h01) begin
          nstrobe_next = 1'b0;
          tmr_next = STB_CYC[7:0];
          state_next = S_CSTB;
        end
      end
      S_CSTB: begin
        if (tmr_reg <= 8'h01) begin
          nstrobe_next = 1'b1;
          tmr_next = HOLD_CYC[7:0];
          state_next = S_CHOLD;
        end
      end
      S_CHOLD: begin
        if (tmr_reg <= 8'h01) begin
          fwd_pop = 1'b1;
          state_next = S_FIDLE;
        end
      end
      S_TOREV: begin
        // bus already released; peripheral may drive once perror falls
        if (!perror_s) begin
          dir_rev_next = 1'b1;
          state_next = S_RIDLE;
        end
      end
      S_RIDLE: begin
        if (!direction_i || !mode_ecp) begin
          if (rep_left_reg == 8'h00) begin
            ninit_next = 1'b1;
            state_next = S_TOFWD;
          end
        end else if (f_in_ready && nack_s && rep_left_reg == 8'h00) begin
          hostack_next = 1'b0;
          state_next = S_RWAIT;
        end
      end
      S_RWAIT: begin
        if (!nack_s) begin
          hostack_next = 1'b1;
          state_next = S_RREL;
          if (!busy_s && !pd_s[`ECPL_CMD_ADDR_BIT]) begin
            rle_pend_next = 1'b1;
            rle_cnt_next = pd_s[`ECPL_RLE_MSB:0];
          end else if (!busy_s) begin
            rep_word_next = {1'b1, pd_s};
            rep_left_next = 8'h01;
          end else begin
            rep_word_next = {1'b0, pd_s};
            rle_pend_next = 1'b0;
            rep_left_next = rle_pend_reg ? {1'b0, rle_cnt_reg} + 8'h01 : 8'h01;
          end
        end else if (!direction_i || !mode_ecp) begin
          // an idle peripheral never answers; a byte started too late is lost
          hostack_next = 1'b1;
          ninit_next = 1'b1;
          state_next = S_TOFWD;
        end
      end
      S_RREL: begin
        if (nack_s) begin
          state_next = S_RIDLE;
        end
      end
      S_TOFWD: begin
        // never drive the data lines before perror returns high
        if (perror_s) begin
          dir_rev_next = 1'b0;
          rle_pend_next = 1'b0;
          pd_oe_next = 1'b1;
          state_next = S_FIDLE;
        end
      end
      default: begin
        state_next = S_FIDLE;
      end
    endcase
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= S_FIDLE;
      tmr_reg <= 8'h00;
      pd_reg <= 8'h00;
      pd_oe_reg <= 1'b1;
      nstrobe_reg <= 1'b1;
      hostack_reg <= 1'b1;
      ninit_reg <= 1'b1;
      dir_rev_reg <= 1'b0;
      rle_pend_reg <= 1'b0;
      rle_cnt_reg <= 7'h00;
      rep_left_reg <= 8'h00;
      rep_word_reg <= 9'h000;
      fault_irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      pd_reg <= pd_next;
      pd_oe_reg <= pd_oe_next;
      nstrobe_reg <= nstrobe_next;
      hostack_reg <= hostack_next;
      ninit_reg <= ninit_next;
      dir_rev_reg <= dir_rev_next;
      rle_pend_reg <= rle_pend_next;
      rle_cnt_reg <= rle_cnt_next;
      rep_left_reg <= rep_left_next;
      rep_word_reg <= rep_word_next;
      // level follows the pin; only meaningful while forward
      fault_irq_reg <= mode_ecp && !dir_rev_reg && ninit_reg && !nfault_s;
    end
  end
endmodule // ecpl_link

`default_nettype wire

//--- ecpl_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecpl_defines.vh"
module ecpl_link_sva (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // host side
  input wire logic [2:0] mode_i,
  input wire logic dma_req_o,
  input wire logic fault_irq_o,
  input wire logic dir_rev_o,
  input wire logic rd_valid_o,
  input wire logic rd_tag_o,
  // pins
  input wire logic [7:0] pd_o,
  input wire logic pd_oe_o,
  input wire logic nstrobe_o,
  input wire logic ninit_o,
  input wire logic nselectin_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_sel_mode: assert property (
    nselectin_o == (mode_i == `ECPL_MODE_ECP)) else $error("nselectin wrong for mode");
  a_idle_no_dma: assert property (
    mode_i != `ECPL_MODE_ECP && mode_i != `ECPL_MODE_COMPAT |-> !dma_req_o)
    else $error("dma request outside fifo modes");
  a_rev_bus_off: assert property (
    dir_rev_o || !ninit_o |-> !pd_oe_o) else $error("data driven while reversed");
  a_rev_need_init: assert property (
    $rose(dir_rev_o) |-> !ninit_o) else $error("reverse without direction request");
  a_oe_back_fwd: assert property (
    $rose(pd_oe_o) |-> ninit_o && !dir_rev_o) else $error("bus driven before forward");
  a_strobe_hold: assert property (
    !nstrobe_o |-> $stable(pd_o) && pd_oe_o) else $error("data moved under strobe");
  // strobe width is long; only a lower bound keeps it robust to the exact count
  a_compat_width: assert property (
    $rose(nstrobe_o) && mode_i == `ECPL_MODE_COMPAT |-> !$past(nstrobe_o, 16))
    else $error("compat strobe too short");
  a_irq_fwd_only: assert property (
    fault_irq_o |-> !dir_rev_o) else $error("fault irq in reverse");
  a_irq_mode: assert property (
    mode_i != `ECPL_MODE_ECP |=> !fault_irq_o) else $error("fault irq outside ecp");
  c_compat: cover property (mode_i == `ECPL_MODE_COMPAT && $rose(nstrobe_o));
  c_turn: cover property ($rose(dir_rev_o));
  c_addr: cover property (rd_valid_o && rd_tag_o);
  c_irq: cover property ($rose(fault_irq_o));
endmodule // ecpl_link_sva
bind ecpl_link ecpl_link_sva i_sva (.*);
`default_nettype wire

//--- ecpl_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecpl_periph_model (
  // host pins, then reply lag
  input wire logic clk_i,
  input wire logic [7:0] pd_i,
  input wire logic nstrobe_i,
  input wire logic nautofd_i,
  input wire logic ninit_i,
  input wire logic nselectin_i,
  input wire logic [3:0] lag_i,
  // peripheral pins
  output logic [7:0] pd_o = 8'hA5,
  output logic busy_o = 1'b0,
  output logic nack_o = 1'b1,
  output logic perror_o = 1'b1
);
  logic [8:0] fwd_q[$];
  logic [8:0] rev_q[$];
  logic [8:0] cur;
  task automatic step();
    @(posedge clk_i);
    #1;
  endtask
  task automatic pause();
    repeat (lag_i + 1) step();
  endtask
  always begin
    step();
    if (!nstrobe_i) begin
      fwd_q.push_back({!nautofd_i, pd_i});
      busy_o = 1'b1;
      while (!nstrobe_i) step();
      pause();
      busy_o = 1'b0;
    end
  end
  always begin
    step();
    perror_o = ninit_i;
  end
  always begin
    step();
    if (!perror_o && !nautofd_i && nselectin_i && rev_q.size() > 0) begin
      cur = rev_q.pop_front();
      pd_o = cur[7:0];
      busy_o = !cur[8];
      pause();
      nack_o = 1'b0;
      while (!nautofd_i) step();
      nack_o = 1'b1;
      // released bus shows the inverse so a stale byte cannot pass
      pd_o = ~cur[7:0];
    end
  end
endmodule // ecpl_periph_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecpl_defines.vh"
module tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] mode_i = 3'h0;
  logic direction_i = 1'b0;
  logic wr_valid_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_tag_i = 1'b0;
  logic rd_ready_i = 1'b0;
  logic nfault_i = 1'b1;
  logic [3:0] lag = 4'h0;
  logic [31:0] seed = 32'h670F;
  logic [8:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  wire logic wr_ready_o, rd_valid_o, rd_tag_o, dma_req_o, fault_irq_o, dir_rev_o, pd_oe_o;
  wire logic nstrobe_o, nautofd_o, ninit_o, nselectin_o, busy_i, nack_i, perror_i;
  wire logic [7:0] rd_data_o, pd_o, mdl_pd, pd_i;
  assign pd_i = pd_oe_o ? pd_o : mdl_pd;
  always #12.5 mclk_i = ~mclk_i;
  ecpl_link #(.DEPTH(16)) i_ecpl_link (.select_i(1'b1), .*);
  ecpl_periph_model i_mdl (.clk_i(mclk_i), .pd_i(pd_i), .nstrobe_i(nstrobe_o),
    .nautofd_i(nautofd_o), .ninit_i(ninit_o), .nselectin_i(nselectin_o), .lag_i(lag),
    .pd_o(mdl_pd), .busy_o(busy_i), .nack_o(nack_i), .perror_o(perror_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [8:0] v);
    wr_valid_i = 1'b1;
    {wr_tag_i, wr_data_i} = v;
    while (wr_ready_o !== 1'b1) tick(1);
    tick(1);
    exp_q.push_back(v);
  endtask
  task automatic fwd_check();
    wr_valid_i = 1'b0;
    while (i_mdl.fwd_q.size() < exp_q.size()) tick(1);
    while (exp_q.size() > 0) chk("fwd byte", exp_q.pop_front(), i_mdl.fwd_q.pop_front());
    tick(40);
  endtask
  task automatic drain();
    rd_ready_i = 1'b1;
    while (exp_q.size() > 0) begin
      if (rd_valid_o === 1'b1) chk("rev byte", exp_q.pop_front(), {rd_tag_o, rd_data_o});
      tick(1);
    end
    rd_ready_i = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    conclude();
  end
  initial begin
    int k;
    logic [7:0] d;
    logic [8:0] v;
    repeat (12) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    tick(3);
    chk("reset pins", 9'h0F, 9'({dir_rev_o, fault_irq_o, pd_oe_o, nstrobe_o, nautofd_o, ninit_o}));
    mode_i = `ECPL_MODE_ECP;
    tick(2);
    chk("ecp idle", 9'h3, 9'({nselectin_o, dma_req_o}));
    for (int i = 0; i < 24; i++) begin
      lag = 4'(rnd());
      wr(9'(rnd()));
    end
    fwd_check();
    mode_i = `ECPL_MODE_COMPAT;
    for (int i = 0; i < 6; i++) wr({1'b0, 8'(rnd())});
    fwd_check();
    mode_i = `ECPL_MODE_ECP;
    nfault_i = 1'b0;
    tick(8);
    chk("fault fwd", 9'h1, 9'({dir_rev_o, fault_irq_o}));
    direction_i = 1'b1;
    while (dir_rev_o !== 1'b1) tick(1);
    tick(4);
    chk("turn", 9'h0, 9'({ninit_o, pd_oe_o, fault_irq_o}));
    for (int i = 0; i < 20; i++) begin
      v = {1'b0, 8'(rnd())};
      i_mdl.rev_q.push_back(v);
      exp_q.push_back(v);
    end
    tick(800);
    chk("rev fill", 9'h004, 9'(i_mdl.rev_q.size()));
    chk("rev dma", 9'h1, 9'(dma_req_o));
    for (int i = 0; i < 12; i++) begin
      k = (i == 0) ? 0 : (i == 1) ? 127 : int'(rnd() % 128);
      d = 8'(rnd());
      lag = 4'(rnd());
      i_mdl.rev_q.push_back({2'b10, 7'(k)});
      i_mdl.rev_q.push_back({1'b0, d});
      repeat (k + 1) exp_q.push_back({1'b0, d});
      v = {2'b11, 7'(rnd())};
      i_mdl.rev_q.push_back(v);
      exp_q.push_back(v);
    end
    drain();
    nfault_i = 1'b1;
    direction_i = 1'b0;
    while (dir_rev_o !== 1'b0) tick(1);
    chk("back fwd", 9'h3, 9'({ninit_o, pd_oe_o}));
    conclude();
  end
endmodule // tb_top
`default_nettype wire
